/* File: capture_compare_timer_regs_tb_top.sv */
`timescale 1ns/1ns
module capture_compare_timer_regs_tb_top;
   import cct_pkg::*;
   logic i_clk = 1'b0;
   logic i_rst_n = 1'b0;
   logic i_psel = 1'b0;
   logic i_penable = 1'b0;
   logic i_pwrite = 1'b0;
   logic [7:0] i_paddr = 8'h00;
   logic [31:0] i_pwdata = 32'h0000_0000;
   logic [3:0] i_pstrb = 4'hF;
   logic [7:0] i_match = 8'h00;
   logic [7:0] i_pin, o_pin, o_pin_oe, o_pin_sync, o_mode_sel, o_flags;
   logic [31:0] o_prdata, x;
   logic o_pready, o_pslverr;
   int fail_count = 0;
   int compares = 0;
   int cycles = 0;
   int tnum = 0;
   cct_byte_t rnd = 8'h4D;
   logic [5:0] tbl [16] = '{6'h00, 6'h01, 6'h02, 6'h03, 6'h04, 6'h06, 6'h07, 6'h08,
      6'h0A, 6'h0C, 6'h0D, 6'h20, 6'h22, 6'h24, 6'h2D, 6'h3F};
   cct_timer_regs dut_u (.i_clk(i_clk), .i_rst_n(i_rst_n), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .i_pstrb(i_pstrb), .o_prdata(o_prdata),
      .o_pready(o_pready), .o_pslverr(o_pslverr), .i_match(i_match), .i_pin(i_pin), .o_pin(o_pin),
      .o_pin_oe(o_pin_oe), .o_pin_sync(o_pin_sync), .o_mode_sel(o_mode_sel), .o_flags(o_flags));
   cct_pin_model pins_u (.i_clk(i_clk), .i_drv(o_pin), .i_oe(o_pin_oe), .o_pad(i_pin));
   always #10 i_clk = ~i_clk;
   function automatic cct_byte_t nxt(input cct_byte_t s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic cct_byte_t exp_mask(input logic [5:0] a);
      if (a == 6'h01 || a >= 6'h24) return 8'h00;
      if (a == 6'h06) return 8'hF0;
      if (a == 6'h0D) return 8'h8F;
      if (a == 6'h20) return 8'h7F;
      return 8'hFF;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic apb(input logic w, input logic [5:0] a, input cct_byte_t v);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_pwrite <= w;
      i_paddr <= {a, 2'b00};
      i_pwdata <= {24'h000000, v};
      @(posedge i_clk);
      i_penable <= 1'b1;
      // The slave may stretch the access phase, so only the edge with ready high ends it
      do begin
         @(posedge i_clk);
      end while (o_pready !== 1'b1);
      x = o_prdata;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
   endtask
   task automatic settle(input int n);
      repeat (n) @(posedge i_clk);
      @(negedge i_clk);
   endtask
   task automatic done_test;
      tnum++;
      $display("test %0d finished", tnum);
   endtask
   task automatic summarize;
      $display("compares %0d mismatches %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   always @(posedge i_clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         summarize();
      end
   end
   initial begin
      repeat (12) @(posedge i_clk);
      i_rst_n <= 1'b1;
      for (int r = 0; r < 2; r++) begin
         foreach (tbl[k]) begin
            rnd = nxt(rnd);
            apb(1'b1, tbl[k], rnd);
            apb(1'b0, tbl[k], 8'h00);
            chk(x, {24'h000000, rnd & exp_mask(tbl[k])});
         end
      end
      done_test();
      apb(1'b1, 6'h00, 8'h00);
      apb(1'b1, 6'h12, 8'hA5);
      apb(1'b0, 6'h12, 8'h00);
      chk(x, 32'h0000_0000);
      apb(1'b1, 6'h00, 8'h02);
      apb(1'b1, 6'h12, 8'hA5);
      apb(1'b0, 6'h12, 8'h00);
      chk(x, 32'h0000_00A5);
      // Without the lane 0 strobe the write must leave the byte alone
      i_pstrb <= 4'hE;
      apb(1'b1, 6'h12, 8'h5A);
      i_pstrb <= 4'hF;
      apb(1'b0, 6'h12, 8'h00);
      chk(x, 32'h0000_00A5);
      done_test();
      apb(1'b1, 6'h09, 8'hE4);
      apb(1'b1, 6'h02, 8'h00);
      apb(1'b1, 6'h00, 8'h0F);
      apb(1'b1, 6'h0E, 8'hFF);
      apb(1'b1, 6'h01, 8'h0E);
      settle(2);
      chk(o_pin[3:2], 2'b10);
      chk(o_pin_oe, 8'h0E);
      chk(o_flags, 8'h00);
      apb(1'b1, 6'h01, 8'h08);
      i_match <= 8'h08;
      @(posedge i_clk);
      i_match <= 8'h00;
      settle(1);
      chk(o_flags, 8'h00);
      chk(o_pin_sync[3:2], 2'b10);
      done_test();
      apb(1'b1, 6'h00, 8'hFF);
      apb(1'b1, 6'h02, 8'h3C);
      rnd = nxt(rnd) & 8'hF7;
      apb(1'b1, 6'h03, rnd);
      i_match <= 8'h88;
      @(posedge i_clk);
      i_match <= 8'h00;
      settle(1);
      chk(o_pin[5:2], rnd[5:2]);
      chk(o_flags, 8'h88);
      done_test();
      summarize();
   end
endmodule
bind cct_timer_regs cct_timer_regs_monitor #(.N_CH(N_CH)) mon_u (.i_clk(i_clk), .i_rst_n(i_rst_n),
   .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata),
   .i_pstrb(i_pstrb), .o_prdata(o_prdata), .o_pready(o_pready), .o_pslverr(o_pslverr), .i_match(i_match),
   .i_pin(i_pin), .o_pin(o_pin), .o_pin_oe(o_pin_oe), .o_pin_sync(o_pin_sync), .o_mode_sel(o_mode_sel),
   .o_flags(o_flags));

/* File: cct_cfg.svh */
`ifndef CCT_CFG_SVH
`define CCT_CFG_SVH
// Register indices; each register takes one aligned word, so the byte address is index * 4
`define CCT_IDX_MODE_SEL 6'h00
`define CCT_IDX_FORCE 6'h01
`define CCT_IDX_C7_MASK 6'h02
`define CCT_IDX_C7_DATA 6'h03
`define CCT_IDX_CNT_HI 6'h04
`define CCT_IDX_CNT_LO 6'h05
`define CCT_IDX_SYSCTL1 6'h06
`define CCT_IDX_TOGGLE_OV 6'h07
`define CCT_IDX_ACT_UP 6'h08
`define CCT_IDX_ACT_LO 6'h09
`define CCT_IDX_EDGE_UP 6'h0A
`define CCT_IDX_EDGE_LO 6'h0B
`define CCT_IDX_INT_EN 6'h0C
`define CCT_IDX_SYSCTL2 6'h0D
`define CCT_IDX_FLAGS 6'h0E
`define CCT_IDX_OV_FLAG 6'h0F
`define CCT_IDX_VAL_BASE 6'h10
`define CCT_IDX_VAL_LAST 6'h1F
`define CCT_IDX_ACC_CTL 6'h20
`define CCT_IDX_ACC_FLG 6'h21
`define CCT_IDX_ACC_HI 6'h22
`define CCT_IDX_ACC_LO 6'h23
// Implemented-bit masks
`define CCT_MASK_SYSCTL1 8'hF0
`define CCT_MASK_SYSCTL2 8'h8F
`define CCT_MASK_OV_FLAG 8'h80
`define CCT_MASK_ACC_CTL 8'h7F
`define CCT_MASK_ACC_FLG 8'h03
// Reset values
`define CCT_RST_BYTE 8'h00
`define CCT_RST_WORD 16'h0000
`define CCT_RST_RDATA 32'h0000_0000
`endif

/* File: cct_pin_model.sv */
`timescale 1ns/1ns
module cct_pin_model (
   input wire logic i_clk, // bus clock
   input wire logic [7:0] i_drv, // block drive level
   input wire logic [7:0] i_oe, // block drive enable
   output logic [7:0] o_pad // resolved pin level
);
   logic [7:0] wander_reg = 8'h3C;
   // Pins have no pull, so undriven pins 0, 2, 5 and 7 toggle every cycle while pins 1, 3, 4 and 6 hold a fixed level
   always_ff @(posedge i_clk) begin
      wander_reg <= wander_reg ^ 8'hA5;
   end
   assign o_pad = (i_drv & i_oe) | (wander_reg & ~i_oe);
endmodule

/* File: cct_pkg.sv */
package cct_pkg;
   typedef logic [7:0] cct_byte_t;
   typedef logic [15:0] cct_word_t;
   typedef logic [1:0] cct_action_t;
endpackage

/* File: cct_timer_regs.sv */
// Our own choice: the APB interface to the registers.
`timescale 1ns/1ns
`include "cct_cfg.svh"
module cct_timer_regs #(
   parameter int N_CH = 8
) (
   input wire logic i_clk, // 50 MHz bus clock
   input wire logic i_rst_n, // Async reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [7:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   input wire logic [3:0] i_pstrb, // APB byte strobes
   output logic [31:0] o_prdata, // APB read data
   output logic o_pready, // APB ready
   output logic o_pslverr, // APB error
   input wire logic [N_CH-1:0] i_match, // Genuine compare match per channel
   input wire logic [N_CH-1:0] i_pin, // Channel pins, asynchronous
   output logic [N_CH-1:0] o_pin, // Channel pin drive level
   output logic [N_CH-1:0] o_pin_oe, // Channel pin output enable
   output logic [N_CH-1:0] o_pin_sync, // Synchronised pin levels
   output logic [N_CH-1:0] o_mode_sel, // Channel mode bits
   output logic [N_CH-1:0] o_flags // Channel event flags
);
   import cct_pkg::*;

   cct_byte_t mode_sel_reg, c7_mask_reg, c7_data_reg;
   cct_byte_t cnt_hi_reg, cnt_lo_reg, sysctl1_reg, toggle_ov_reg;
   cct_byte_t act_up_reg, act_lo_reg, edge_up_reg, edge_lo_reg;
   cct_byte_t int_en_reg, sysctl2_reg, flags_reg, ov_flag_reg;
   cct_byte_t acc_ctl_reg, acc_flg_reg, acc_hi_reg, acc_lo_reg;
   cct_word_t val_reg [N_CH];
   logic [N_CH-1:0] force_reg;
   logic [N_CH-1:0] pin_reg, pin_next;
   logic [N_CH-1:0] sync1_reg, sync2_reg;
   logic [N_CH-1:0] fire;
   logic [N_CH-1:0] oe_act;
   logic [15:0] action_bits;
   logic [5:0] idx;
   logic wr_en, rd_en, c7_event;
   cct_byte_t wbyte, rbyte, flags_next;

   // Registers take a full word but only byte lane 0 carries data
   assign idx = i_paddr[7:2];
   assign wr_en = i_psel && i_penable && i_pwrite && i_pstrb[0];
   assign rd_en = i_psel && i_penable && !i_pwrite;
   assign wbyte = i_pwdata[7:0];
   assign o_pready = 1'b1;
   assign o_pslverr = 1'b0;
   assign action_bits = {act_up_reg, act_lo_reg};
   assign o_mode_sel = mode_sel_reg;
   assign o_flags = flags_reg;

   // Two-stage synchroniser for the pins
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         sync1_reg <= '0;
         sync2_reg <= '0;
      end else begin
         sync1_reg <= i_pin;
         sync2_reg <= sync1_reg;
      end
   end
   assign o_pin_sync = sync2_reg;

   // Force bits live for one cycle only
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         force_reg <= '0;
      end else if (wr_en && idx == `CCT_IDX_FORCE) begin
         force_reg <= wbyte;
      end else begin
         force_reg <= '0;
      end
   end

   // A channel acts when it is in compare mode and matched or was forced
   assign fire = mode_sel_reg & (i_match | force_reg);
   assign c7_event = fire[N_CH-1];

   // Pin actions: 00 none, 01 toggle, 10 clear, 11 set; channel 7 mask applied last so it wins
   always_comb begin
      pin_next = pin_reg;
      for (int i = 0; i < N_CH; i++) begin
         if (fire[i]) begin
            case (action_bits[2*i +: 2])
               2'b01: pin_next[i] = !pin_reg[i];
               2'b10: pin_next[i] = 1'b0;
               2'b11: pin_next[i] = 1'b1;
               default: pin_next[i] = pin_reg[i];
            endcase
         end
      end
      if (c7_event) begin
         for (int i = 0; i < N_CH; i++) begin
            if (c7_mask_reg[i]) begin
               pin_next[i] = c7_data_reg[i];
            end
         end
      end
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         pin_reg <= '0;
      end else begin
         pin_reg <= pin_next;
      end
   end
   assign o_pin = pin_reg;
   // Mask bits of 0..6 also turn a compare channel's pin into an output
   generate
      for (genvar c = 0; c < N_CH; c++) begin : g_oe
         assign oe_act[c] = |action_bits[2*c +: 2];
      end
   endgenerate
   assign o_pin_oe = mode_sel_reg & ({1'b0, c7_mask_reg[N_CH-2:0]} | oe_act);

   // Event flags: a genuine match on a compare channel sets, force suppresses it, set wins over write-one-to-clear
   always_comb begin
      flags_next = flags_reg;
      if (wr_en && idx == `CCT_IDX_FLAGS) begin
         flags_next = flags_reg & ~wbyte;
      end
      flags_next = flags_next | (mode_sel_reg & i_match & ~force_reg);
   end

   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         flags_reg <= `CCT_RST_BYTE;
      end else begin
         flags_reg <= flags_next;
      end
   end

   // Control registers and the write-one-to-clear ov_flag_reg and acc_flg_reg, unimplemented bits masked off
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         mode_sel_reg <= `CCT_RST_BYTE;
         c7_mask_reg <= `CCT_RST_BYTE;
         c7_data_reg <= `CCT_RST_BYTE;
         cnt_hi_reg <= `CCT_RST_BYTE;
         cnt_lo_reg <= `CCT_RST_BYTE;
         sysctl1_reg <= `CCT_RST_BYTE;
         toggle_ov_reg <= `CCT_RST_BYTE;
         act_up_reg <= `CCT_RST_BYTE;
         act_lo_reg <= `CCT_RST_BYTE;
         edge_up_reg <= `CCT_RST_BYTE;
         edge_lo_reg <= `CCT_RST_BYTE;
         int_en_reg <= `CCT_RST_BYTE;
         sysctl2_reg <= `CCT_RST_BYTE;
         ov_flag_reg <= `CCT_RST_BYTE;
         acc_ctl_reg <= `CCT_RST_BYTE;
         acc_flg_reg <= `CCT_RST_BYTE;
         acc_hi_reg <= `CCT_RST_BYTE;
         acc_lo_reg <= `CCT_RST_BYTE;
      end else if (wr_en) begin
         case (idx)
            `CCT_IDX_MODE_SEL: mode_sel_reg <= wbyte;
            `CCT_IDX_C7_MASK: c7_mask_reg <= wbyte;
            `CCT_IDX_C7_DATA: c7_data_reg <= wbyte;
            `CCT_IDX_CNT_HI: cnt_hi_reg <= wbyte;
            `CCT_IDX_CNT_LO: cnt_lo_reg <= wbyte;
            `CCT_IDX_SYSCTL1: sysctl1_reg <= wbyte & `CCT_MASK_SYSCTL1;
            `CCT_IDX_TOGGLE_OV: toggle_ov_reg <= wbyte;
            `CCT_IDX_ACT_UP: act_up_reg <= wbyte;
            `CCT_IDX_ACT_LO: act_lo_reg <= wbyte;
            `CCT_IDX_EDGE_UP: edge_up_reg <= wbyte;
            `CCT_IDX_EDGE_LO: edge_lo_reg <= wbyte;
            `CCT_IDX_INT_EN: int_en_reg <= wbyte;
            `CCT_IDX_SYSCTL2: sysctl2_reg <= wbyte & `CCT_MASK_SYSCTL2;
            `CCT_IDX_OV_FLAG: ov_flag_reg <= ov_flag_reg & ~(wbyte & `CCT_MASK_OV_FLAG);
            `CCT_IDX_ACC_CTL: acc_ctl_reg <= wbyte & `CCT_MASK_ACC_CTL;
            `CCT_IDX_ACC_FLG: acc_flg_reg <= acc_flg_reg & ~(wbyte & `CCT_MASK_ACC_FLG);
            `CCT_IDX_ACC_HI: acc_hi_reg <= wbyte;
            `CCT_IDX_ACC_LO: acc_lo_reg <= wbyte;
            default: mode_sel_reg <= mode_sel_reg;
         endcase
      end
   end

   // Value registers: index pairs hold high then low byte of each channel
   genvar g;
   generate
      for (g = 0; g < N_CH; g++) begin : g_val
         always_ff @(posedge i_clk or negedge i_rst_n) begin
            if (!i_rst_n) begin
               val_reg[g] <= `CCT_RST_WORD;
            end else if (wr_en && mode_sel_reg[g]) begin
               if (idx == `CCT_IDX_VAL_BASE + 6'(2 * g)) begin
                  val_reg[g][15:8] <= wbyte;
               end else if (idx == `CCT_IDX_VAL_BASE + 6'(2 * g + 1)) begin
                  val_reg[g][7:0] <= wbyte;
               end
            end
         end
      end
   endgenerate

   // Read mux
   always_comb begin
      rbyte = `CCT_RST_BYTE;
      case (idx)
         `CCT_IDX_MODE_SEL: rbyte = mode_sel_reg;
         `CCT_IDX_FORCE: rbyte = `CCT_RST_BYTE;
         `CCT_IDX_C7_MASK: rbyte = c7_mask_reg;
         `CCT_IDX_C7_DATA: rbyte = c7_data_reg;
         `CCT_IDX_CNT_HI: rbyte = cnt_hi_reg;
         `CCT_IDX_CNT_LO: rbyte = cnt_lo_reg;
         `CCT_IDX_SYSCTL1: rbyte = sysctl1_reg;
         `CCT_IDX_TOGGLE_OV: rbyte = toggle_ov_reg;
         `CCT_IDX_ACT_UP: rbyte = act_up_reg;
         `CCT_IDX_ACT_LO: rbyte = act_lo_reg;
         `CCT_IDX_EDGE_UP: rbyte = edge_up_reg;
         `CCT_IDX_EDGE_LO: rbyte = edge_lo_reg;
         `CCT_IDX_INT_EN: rbyte = int_en_reg;
         `CCT_IDX_SYSCTL2: rbyte = sysctl2_reg;
         `CCT_IDX_FLAGS: rbyte = flags_reg;
         `CCT_IDX_OV_FLAG: rbyte = ov_flag_reg;
         `CCT_IDX_ACC_CTL: rbyte = acc_ctl_reg;
         `CCT_IDX_ACC_FLG: rbyte = acc_flg_reg;
         `CCT_IDX_ACC_HI: rbyte = acc_hi_reg;
         `CCT_IDX_ACC_LO: rbyte = acc_lo_reg;
         default: begin
            if (idx >= `CCT_IDX_VAL_BASE && idx <= `CCT_IDX_VAL_LAST) begin
               rbyte = idx[0] ? val_reg[idx[3:1]][7:0] : val_reg[idx[3:1]][15:8];
            end else begin
               rbyte = `CCT_RST_BYTE;
            end
         end
      endcase
   end

   // Read data is registered during the setup phase so it is stable in the access phase
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         o_prdata <= `CCT_RST_RDATA;
      end else if (i_psel && !i_penable && !i_pwrite) begin
         o_prdata <= {24'h000000, rbyte};
      end else if (rd_en) begin
         o_prdata <= o_prdata;
      end else begin
         o_prdata <= `CCT_RST_RDATA;
      end
   end
endmodule

/* File: cct_timer_regs_monitor.sv */
`timescale 1ns/1ns
module cct_timer_regs_monitor #(
   parameter int N_CH = 8
) (
   input wire logic i_clk, // Bus clock
   input wire logic i_rst_n, // Async reset, active low
   input wire logic i_psel, // APB select
   input wire logic i_penable, // APB enable
   input wire logic i_pwrite, // APB direction
   input wire logic [7:0] i_paddr, // APB byte address
   input wire logic [31:0] i_pwdata, // APB write data
   input wire logic [3:0] i_pstrb, // APB byte strobes
   input wire logic [31:0] o_prdata, // APB read data
   input wire logic o_pready, // APB ready
   input wire logic o_pslverr, // APB error
   input wire logic [N_CH-1:0] i_match, // Genuine matches
   input wire logic [N_CH-1:0] i_pin, // Pin levels
   input wire logic [N_CH-1:0] o_pin, // Pin drive
   input wire logic [N_CH-1:0] o_pin_oe, // Pin enable
   input wire logic [N_CH-1:0] o_pin_sync, // Synchronised pins
   input wire logic [N_CH-1:0] o_mode_sel, // Mode bits
   input wire logic [N_CH-1:0] o_flags // Event flags
);
   logic [7:0] msk_reg, dat_reg, frc_reg;
   wire logic wr = i_psel & i_penable & i_pwrite & i_pstrb[0];
   wire logic rd = i_psel & i_penable & ~i_pwrite;
   wire logic [5:0] idx = i_paddr[7:2];
   // Override mask and data are not ports, so shadow them from bus writes
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         msk_reg <= 8'h00;
         dat_reg <= 8'h00;
         frc_reg <= 8'h00;
      end else begin
         msk_reg <= (wr && idx == 6'h02) ? i_pwdata[7:0] : msk_reg;
         dat_reg <= (wr && idx == 6'h03) ? i_pwdata[7:0] : dat_reg;
         frc_reg <= (wr && idx == 6'h01) ? i_pwdata[7:0] : 8'h00;
      end
   end
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);
   ready_no_error_a:
      assert property (o_pready && !o_pslverr) else $error("bus stalled or erred");
   force_reads_zero_a:
      assert property (rd && idx == 6'h01 |-> o_prdata == 32'h0000_0000) else $error("force read not zero");
   reserved_reads_zero_a:
      assert property (rd && idx >= 6'h24 |-> o_prdata == 32'h0000_0000) else $error("reserved read not zero");
   upper_bits_zero_a:
      assert property (i_psel && i_penable |-> o_prdata[31:8] == 24'h000000) else $error("upper bits set");
   mode_follows_write_a:
      assert property (wr && idx == 6'h00 |=> o_mode_sel == $past(i_pwdata[7:0])) else $error("mode bits wrong");
   capture_no_drive_a:
      assert property ((o_pin_oe & ~o_mode_sel) == 8'h00) else $error("capture channel driven");
   flag_needs_match_a:
      assert property (1'b1 |=> (o_flags & ~$past(o_flags) & ~$past(i_match & o_mode_sel)) == 8'h00)
         else $error("flag without match");
   force_beats_flag_a:
      assert property (|(frc_reg & i_match & o_mode_sel) |=> (o_flags & ~$past(o_flags) & $past(frc_reg)) == 8'h00)
         else $error("forced flag set");
   c7_override_a:
      assert property (i_match[7] && o_mode_sel[7] && frc_reg == 8'h00 |=>
         ((o_pin ^ $past(dat_reg)) & $past(msk_reg & o_mode_sel) & 8'h7F) == 8'h00) else $error("override lost");
   force_seen_c: cover property (frc_reg != 8'h00);
   c7_event_c: cover property (i_match[7] && o_mode_sel[7]);
   reserved_read_c: cover property (rd && idx >= 6'h24);
endmodule
